// ---- rtl/fbs_params.svh ----
// Purpose: constants for the fieldbus slave sync/config front end
// Assumes: 100 MHz MCLK_I
// Notes:   times in ns, us or ms as each name says, cycle counts derived
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH
`define FBS_CLK_PERIOD_NS   10
`define FBS_MIN_CYCLE_NS    1000000
`define FBS_MIN_CYCLE_CLKS  (`FBS_MIN_CYCLE_NS / `FBS_CLK_PERIOD_NS)
`define FBS_DC_Q_US         250
`define FBS_DC_H_US         500
`define FBS_DC_MAX_MS       8
`define FBS_SM_MBX_OUT      2'h0
`define FBS_SM_MBX_IN       2'h1
`define FBS_SM_PD_OUT       2'h2
`define FBS_SM_PD_IN        2'h3
`define FBS_ADDR_RST        16'h0000
`define FBS_PARAM_RST       32'h00000000
`endif

// ---- rtl/fbs_pkg.sv ----
// Purpose: types for the fieldbus slave sync/config front end
// Assumes: nothing
// Notes:   none
`default_nettype none
package fbs_pkg;
  typedef enum logic [1:0] {FBS_UPD_IMM, FBS_UPD_STOP, FBS_UPD_CFG, FBS_UPD_PWR} fbs_upd_t;
  typedef enum logic [1:0] {FBS_SYNC_FREE, FBS_SYNC_SM2, FBS_SYNC_DC} fbs_sync_t;
  typedef enum logic [1:0] {FBS_ESM_INIT, FBS_ESM_PREOP, FBS_ESM_SAFEOP, FBS_ESM_OP} fbs_esm_t;
endpackage : fbs_pkg
`default_nettype wire

// ---- rtl/fbs_sync_config.sv ----
// Purpose: node address capture, parameter update classes, sync mode checks
// Assumes: frame engine, state machine and parameter store live outside
// Notes:   upd class arrives with each write strobe
//          SYS_RST_I also stands in for a control power cycle
`include "fbs_params.svh"
`default_nettype none
module fbs_sync_config #(
  parameter int NPARAM = 4,
  parameter int PW     = 32
) (
  input  wire logic              MCLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic [3:0]        NODE_TENS_I,
  input  wire logic [3:0]        NODE_ONES_I,
  input  wire logic              PWR_UP_DONE_I,
  input  wire logic              PAR_WR_I,
  input  wire logic [1:0]        PAR_IDX_I,
  input  wire logic [PW-1:0]     PAR_DATA_I,
  input  wire logic [1:0]        PAR_CLASS_I,
  input  wire logic              MOTOR_STOPPED_I,
  input  wire logic              CONFIGURE_I,
  input  wire logic [1:0]        ESM_STATE_I,
  input  wire logic [1:0]        SYNC_MODE_I,
  input  wire logic [31:0]       CYCLE_NS_I,
  input  wire logic              SYNC0_I,
  input  wire logic              SM2_EVT_I,
  input  wire logic              MAP_WR_I,
  input  wire logic              RX_FRAME_I,
  input  wire logic              UP_RX_I,
  input  wire logic              DN_RX_I,
  output logic [15:0]            NODE_ADDR_O,
  output logic [NPARAM*PW-1:0]   PAR_ACTIVE_O,
  output logic [NPARAM*PW-1:0]   PAR_PENDING_O,
  output logic                   SYNC_CFG_ERR_O,
  output logic                   CYCLE_TICK_O,
  output logic                   MBX_EN_O,
  output logic                   TXPDO_EN_O,
  output logic                   RXPDO_EN_O,
  output logic                   MAP_WR_OK_O,
  output logic [1:0]             SM_MBX_OUT_O,
  output logic [1:0]             SM_MBX_IN_O,
  output logic [1:0]             SM_PD_OUT_O,
  output logic [1:0]             SM_PD_IN_O,
  output logic                   DN_TX_O,
  output logic                   UP_TX_O
);
  localparam logic [31:0] MIN_CYC   = 32'(`FBS_MIN_CYCLE_NS);
  localparam logic [31:0] MS_NS     = 32'(`FBS_MIN_CYCLE_NS);
  localparam logic [31:0] DC_Q_NS   = 32'(`FBS_DC_Q_US * 1000);
  localparam logic [31:0] DC_H_NS   = 32'(`FBS_DC_H_US * 1000);
  localparam logic [31:0] DC_MAX_NS = 32'(`FBS_DC_MAX_MS * `FBS_MIN_CYCLE_NS);

  // two-flop synchronisers for pins; only the second stage feeds logic
  // sy_s3 is the edge detector stage behind the sync0 synchroniser
  logic [7:0] sw_s1;
  logic [7:0] sw_s2;
  logic [7:0] next_sw_s1;
  logic [7:0] next_sw_s2;
  logic       pu_s1;
  logic       pu_s2;
  logic       sy_s1;
  logic       sy_s2;
  logic       sy_s3;
  logic       up_s1;
  logic       up_s2;
  logic       dn_s1;
  logic       dn_s2;
  logic       next_pu_s1;
  logic       next_pu_s2;
  logic       next_sy_s1;
  logic       next_sy_s2;
  logic       next_sy_s3;
  logic       next_up_s1;
  logic       next_up_s2;
  logic       next_dn_s1;
  logic       next_dn_s2;
  always_comb begin
    next_sw_s1 = {NODE_TENS_I, NODE_ONES_I};
    next_sw_s2 = sw_s1;
    next_pu_s1 = PWR_UP_DONE_I;
    next_pu_s2 = pu_s1;
    next_sy_s1 = SYNC0_I;
    next_sy_s2 = sy_s1;
    next_sy_s3 = sy_s2;
    next_up_s1 = UP_RX_I;
    next_up_s2 = up_s1;
    next_dn_s1 = DN_RX_I;
    next_dn_s2 = dn_s1;
  end
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sw_s1 <= 8'h00;
      sw_s2 <= 8'h00;
      pu_s1 <= 1'b0;
      pu_s2 <= 1'b0;
      sy_s1 <= 1'b0;
      sy_s2 <= 1'b0;
      sy_s3 <= 1'b0;
      up_s1 <= 1'b0;
      up_s2 <= 1'b0;
      dn_s1 <= 1'b0;
      dn_s2 <= 1'b0;
    end else begin
      sw_s1 <= next_sw_s1;
      sw_s2 <= next_sw_s2;
      pu_s1 <= next_pu_s1;
      pu_s2 <= next_pu_s2;
      sy_s1 <= next_sy_s1;
      sy_s2 <= next_sy_s2;
      sy_s3 <= next_sy_s3;
      up_s1 <= next_up_s1;
      up_s2 <= next_up_s2;
      dn_s1 <= next_dn_s1;
      dn_s2 <= next_dn_s2;
    end
  end

  // node address: latched once after power-up, switch moves later ignored
  logic        addr_taken;
  logic        next_addr_taken;
  logic [15:0] node_addr;
  logic [15:0] next_node_addr;
  always_comb begin
    next_addr_taken = addr_taken;
    next_node_addr  = node_addr;
    if (pu_s2 && !addr_taken) begin
      next_node_addr  = 16'({4'h0, sw_s2[7:4]} * 8'd10) + 16'({12'h000, sw_s2[3:0]});
      next_addr_taken = 1'b1;
    end
  end
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      addr_taken <= 1'b0;
      node_addr  <= `FBS_ADDR_RST;
    end else begin
      addr_taken <= next_addr_taken;
      node_addr  <= next_node_addr;
    end
  end
  assign NODE_ADDR_O = node_addr;

  // parameter slots: pending shadow and active copy per slot
  // a power cycle asserts SYS_RST_I: cfg writes wait for a configure, pwr writes for reset;
  // the store reloads saved values through PAR_WR_I before power-up is done
  genvar g;
  generate
    for (g = 0; g < NPARAM; g++) begin : g_par
      logic [PW-1:0] act;
      logic [PW-1:0] pend;
      logic [PW-1:0] next_act;
      logic [PW-1:0] next_pend;
      logic          dirty;
      logic          next_dirty;
      logic [1:0]    cls;
      logic [1:0]    next_cls;
      always_comb begin
        next_act   = act;
        next_pend  = pend;
        next_dirty = dirty;
        next_cls   = cls;
        if (dirty && ((cls == fbs_pkg::FBS_UPD_STOP && MOTOR_STOPPED_I)
                   || (cls == fbs_pkg::FBS_UPD_CFG && CONFIGURE_I))) begin
          next_act   = pend;
          next_dirty = 1'b0;
        end
        if (PAR_WR_I && PAR_IDX_I == 2'(g)) begin
          next_pend = PAR_DATA_I;
          next_cls  = PAR_CLASS_I;
          if (PAR_CLASS_I == fbs_pkg::FBS_UPD_IMM || !pu_s2) begin
            next_act   = PAR_DATA_I;
            next_dirty = 1'b0;
          end else begin
            next_dirty = 1'b1;
          end
        end
      end
      always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          act   <= `FBS_PARAM_RST;
          pend  <= `FBS_PARAM_RST;
          dirty <= 1'b0;
          cls   <= 2'h0;
        end else begin
          act   <= next_act;
          pend  <= next_pend;
          dirty <= next_dirty;
          cls   <= next_cls;
        end
      end
      assign PAR_ACTIVE_O[g*PW +: PW]  = act;
      assign PAR_PENDING_O[g*PW +: PW] = pend;
    end
  endgenerate

  // cycle time check against the set allowed for the mode
  // modulo is acceptable: the cycle is a static setting, not a per-frame value
  logic cyc_bad;
  logic cfg_err;
  logic next_cfg_err;
  always_comb begin
    case (SYNC_MODE_I)
      fbs_pkg::FBS_SYNC_FREE: cyc_bad = CYCLE_NS_I < MIN_CYC;
      fbs_pkg::FBS_SYNC_SM2:  cyc_bad = CYCLE_NS_I < MIN_CYC;
      fbs_pkg::FBS_SYNC_DC:   cyc_bad = !(CYCLE_NS_I == DC_Q_NS || CYCLE_NS_I == DC_H_NS
                                || (CYCLE_NS_I >= MS_NS && CYCLE_NS_I <= DC_MAX_NS
                                    && (CYCLE_NS_I % MS_NS) == 32'h0));
      default:                cyc_bad = 1'b1;
    endcase
    next_cfg_err = cyc_bad;
  end
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      // shut until the first check so cyclic gating starts closed
      cfg_err <= 1'b1;
    end else begin
      cfg_err <= next_cfg_err;
    end
  end
  assign SYNC_CFG_ERR_O = cfg_err;

  // cyclic tick source and state gating
  logic tick;
  logic next_tick;
  logic mbx;
  logic tx;
  logic rx;
  logic next_mbx;
  logic next_tx;
  logic next_rx;
  logic cyclic;
  always_comb begin
    cyclic = (ESM_STATE_I == fbs_pkg::FBS_ESM_SAFEOP || ESM_STATE_I == fbs_pkg::FBS_ESM_OP)
             && !cfg_err;
    case (SYNC_MODE_I)
      fbs_pkg::FBS_SYNC_DC:  next_tick = cyclic && sy_s2 && !sy_s3;
      fbs_pkg::FBS_SYNC_SM2: next_tick = cyclic && SM2_EVT_I;
      default:               next_tick = cyclic && RX_FRAME_I;
    endcase
    next_mbx = ESM_STATE_I != fbs_pkg::FBS_ESM_INIT;
    next_tx  = cyclic;
    next_rx  = cyclic && ESM_STATE_I == fbs_pkg::FBS_ESM_OP;
  end
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tick <= 1'b0;
      mbx  <= 1'b0;
      tx   <= 1'b0;
      rx   <= 1'b0;
    end else begin
      tick <= next_tick;
      mbx  <= next_mbx;
      tx   <= next_tx;
      rx   <= next_rx;
    end
  end
  assign CYCLE_TICK_O = tick;
  assign MBX_EN_O     = mbx;
  assign TXPDO_EN_O   = tx;
  assign RXPDO_EN_O   = rx;
  // comb so the store can gate the write in its own cycle
  assign MAP_WR_OK_O  = MAP_WR_I && ESM_STATE_I == fbs_pkg::FBS_ESM_PREOP;

  // fixed sync manager roles
  assign SM_MBX_OUT_O = `FBS_SM_MBX_OUT;
  assign SM_MBX_IN_O  = `FBS_SM_MBX_IN;
  assign SM_PD_OUT_O  = `FBS_SM_PD_OUT;
  assign SM_PD_IN_O   = `FBS_SM_PD_IN;

  // pass-through, no address dependence so chain length is unbounded here
  logic dn_tx;
  logic up_tx;
  logic next_dn_tx;
  logic next_up_tx;
  always_comb begin
    next_dn_tx = up_s2;
    next_up_tx = dn_s2;
  end
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dn_tx <= 1'b0;
      up_tx <= 1'b0;
    end else begin
      dn_tx <= next_dn_tx;
      up_tx <= next_up_tx;
    end
  end
  assign DN_TX_O = dn_tx;
  assign UP_TX_O = up_tx;
endmodule : fbs_sync_config
`default_nettype wire

// ---- verif/fbs_master_model.sv ----
// Purpose: master-side timing events for the sync/config front end
// Assumes: cycle shortened to SYNC_CLKS clocks, CYCLE_NS_I carries the nominal value
// Notes:   frame events run at an unrelated rate so DC alignment is visible
`default_nettype none
module fbs_master_model #(
  parameter int SYNC_CLKS = 100
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      sync0_o,
  output logic      frame_o
);
  timeunit 1ns / 1ps;
  int cnt;
  always @(posedge clk_i or posedge rst_i) cnt <= rst_i ? 0 : (cnt + 1) % SYNC_CLKS;
  // sync0 wide enough for the pin synchroniser
  assign sync0_o = rst_i ? 1'b0 : (cnt >= 1 && cnt < 5);
  assign frame_o = rst_i ? 1'b0 : (cnt % 7 == 3);
endmodule : fbs_master_model
`default_nettype wire

// ---- verif/fbs_sync_config_assertions.sv ----
// Purpose: port-level checks for the sync/config front end
// Assumes: bound into every fbs_sync_config
// Notes:   slot g of the parameter buses sits at [g*PW+:PW]
`default_nettype none
module fbs_sync_config_assertions #(
  parameter int NPARAM = 4,
  parameter int PW     = 32
) (
  input wire logic                 MCLK_I,
  input wire logic                 SYS_RST_I,
  input wire logic                 PWR_UP_DONE_I,
  input wire logic                 PAR_WR_I,
  input wire logic [1:0]           PAR_IDX_I,
  input wire logic [PW-1:0]        PAR_DATA_I,
  input wire logic [1:0]           PAR_CLASS_I,
  input wire logic                 MOTOR_STOPPED_I,
  input wire logic                 CONFIGURE_I,
  input wire logic [1:0]           ESM_STATE_I,
  input wire logic [1:0]           SYNC_MODE_I,
  input wire logic [31:0]          CYCLE_NS_I,
  input wire logic                 MAP_WR_I,
  input wire logic                 UP_RX_I,
  input wire logic                 DN_RX_I,
  input wire logic [15:0]          NODE_ADDR_O,
  input wire logic [NPARAM*PW-1:0] PAR_ACTIVE_O,
  input wire logic [NPARAM*PW-1:0] PAR_PENDING_O,
  input wire logic                 SYNC_CFG_ERR_O,
  input wire logic                 CYCLE_TICK_O,
  input wire logic                 MBX_EN_O,
  input wire logic                 TXPDO_EN_O,
  input wire logic                 RXPDO_EN_O,
  input wire logic                 MAP_WR_OK_O,
  input wire logic                 DN_TX_O,
  input wire logic                 UP_TX_O
);
  timeunit 1ns / 1ps;
  logic [PW-1:0] held;
  always_ff @(posedge MCLK_I) held <= PAR_ACTIVE_O[PAR_IDX_I*PW+:PW];
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // three edges so the power-up synchroniser has settled
  sequence s_quiet;
    (!MOTOR_STOPPED_I && !CONFIGURE_I && PWR_UP_DONE_I) [*3];
  endsequence
  AST_IMM: assert property (PAR_WR_I && PAR_CLASS_I == 2'h0 |=>
    PAR_ACTIVE_O[$past(PAR_IDX_I)*PW+:PW] == $past(PAR_DATA_I)) else $error("imm lost");
  AST_PEND: assert property (PAR_WR_I |=>
    PAR_PENDING_O[$past(PAR_IDX_I)*PW+:PW] == $past(PAR_DATA_I)) else $error("pend lost");
  AST_HOLD: assert property (s_quiet ##0 (PAR_WR_I && PAR_CLASS_I != 2'h0) |=>
    PAR_ACTIVE_O[$past(PAR_IDX_I)*PW+:PW] == held) else $error("deferred applied early");
  AST_ADDR: assert property (PWR_UP_DONE_I [*8] |=> $stable(NODE_ADDR_O))
    else $error("address moved");
  AST_PREOP: assert property (ESM_STATE_I == 2'h1 |=>
    MBX_EN_O && !TXPDO_EN_O && !RXPDO_EN_O) else $error("preop gating");
  AST_SAFEOP: assert property (ESM_STATE_I == 2'h2 && !SYNC_CFG_ERR_O |=>
    MBX_EN_O && TXPDO_EN_O && !RXPDO_EN_O) else $error("safeop gating");
  AST_MAP: assert property (MAP_WR_OK_O == (MAP_WR_I && ESM_STATE_I == 2'h1))
    else $error("map gating");
  AST_DNPASS: assert property (1'b1 |-> ##3 (DN_TX_O == $past(UP_RX_I, 3)))
    else $error("downstream pass");
  AST_UPPASS: assert property (1'b1 |-> ##3 (UP_TX_O == $past(DN_RX_I, 3)))
    else $error("upstream pass");
  AST_SLOW: assert property (SYNC_MODE_I inside {2'h0, 2'h1} |=>
    SYNC_CFG_ERR_O == ($past(CYCLE_NS_I) < 32'h000F4240)) else $error("min cycle");
  AST_DC: assert property (SYNC_MODE_I == 2'h2 &&
    CYCLE_NS_I inside {32'h0003D090, 32'h0007A120} |=> !SYNC_CFG_ERR_O) else $error("dc set");
  AST_DCLONG: assert property (SYNC_MODE_I == 2'h2 && CYCLE_NS_I > 32'h007A1200 |=>
    SYNC_CFG_ERR_O) else $error("dc long cycle accepted");
  AST_BADMODE: assert property (SYNC_MODE_I == 2'h3 |=> SYNC_CFG_ERR_O)
    else $error("bad mode accepted");
  AST_NOCYC: assert property (SYNC_CFG_ERR_O |=>
    !TXPDO_EN_O && !RXPDO_EN_O && !CYCLE_TICK_O) else $error("cyclic despite error");
endmodule : fbs_sync_config_assertions
bind fbs_sync_config fbs_sync_config_assertions #(.NPARAM(NPARAM), .PW(PW)) u_chk (.*);
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for fbs_sync_config
// Assumes: master model supplies SYNC0 and frame events
// Notes:   deferred classes checked without a power cycle
`default_nettype none
module testbench;
  timeunit 1ns / 1ps;
  logic         MCLK_I = 1'b0;
  logic         SYS_RST_I = 1'b1;
  logic [3:0]   tens = 4'h4, ones = 4'h2;
  logic         pwr = 1'b0, wr = 1'b0, stopped = 1'b0, cfg = 1'b0, map = 1'b0;
  logic         up = 1'b0, dn = 1'b0;
  logic [1:0]   idx = 2'h0, cls = 2'h0, esm = 2'h0, mode = 2'h0;
  logic [31:0]  data = 32'h0, cyc = 32'h000F4240;
  logic [7:0]   sm, pat = 8'h0;
  logic         sync0, frame, tick, err, mbx, txe, rxe, mok;
  logic [15:0]  addr;
  logic [127:0] act, pend;
  logic         dtx, utx;
  logic [2:0]   upd = 3'h0, dnd = 3'h0;
  int           mismatches = 0, num_checks = 0, ticks = 0;
  fbs_master_model u_master (.clk_i(MCLK_I), .rst_i(SYS_RST_I), .sync0_o(sync0), .frame_o(frame));
  fbs_sync_config DUT (
    .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .NODE_TENS_I(tens), .NODE_ONES_I(ones),
    .PWR_UP_DONE_I(pwr), .PAR_WR_I(wr), .PAR_IDX_I(idx), .PAR_DATA_I(data),
    .PAR_CLASS_I(cls), .MOTOR_STOPPED_I(stopped), .CONFIGURE_I(cfg), .ESM_STATE_I(esm),
    .SYNC_MODE_I(mode), .CYCLE_NS_I(cyc), .SYNC0_I(sync0), .SM2_EVT_I(frame),
    .MAP_WR_I(map), .RX_FRAME_I(frame), .UP_RX_I(up), .DN_RX_I(dn), .NODE_ADDR_O(addr),
    .PAR_ACTIVE_O(act), .PAR_PENDING_O(pend), .SYNC_CFG_ERR_O(err), .CYCLE_TICK_O(tick),
    .MBX_EN_O(mbx), .TXPDO_EN_O(txe), .RXPDO_EN_O(rxe), .MAP_WR_OK_O(mok),
    .SM_MBX_OUT_O(sm[1:0]), .SM_MBX_IN_O(sm[3:2]), .SM_PD_OUT_O(sm[5:4]),
    .SM_PD_IN_O(sm[7:6]), .DN_TX_O(dtx), .UP_TX_O(utx));
  initial forever #5 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) if (tick === 1'b1) ticks <= ticks + 1;
  // port bits as the design sampled them, for the pass-through checks
  always @(posedge MCLK_I) {upd, dnd} <= {upd[1:0], up, dnd[1:0], dn};
  // port traffic stays quiet through reset so the delay checks start clean
  always @(posedge MCLK_I) begin
    #1;
    pat = pat + {7'h0, !SYS_RST_I};
    {up, dn} = {pat[0] ^ pat[2], pat[1]};
  end
  task automatic step(input int n);
    repeat (n) @(posedge MCLK_I);
    #1;
  endtask : step
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // leaves the strobe high so back-to-back writes never re-assign it in one step
  task automatic put(input logic [1:0] i, input logic [1:0] c, input logic [31:0] d);
    {idx, cls, data, wr} = {i, c, d, 1'b1};
    step(1);
  endtask : put
  task automatic sc(input logic [1:0] m, input logic [31:0] c, input logic e);
    {mode, cyc} = {m, c};
    step(2);
    chk("cfg err", err, e);
  endtask : sc
  task automatic t_addr;
    pwr = 1'b1;
    step(5);
    chk("addr", addr, 128'h2A);
    tens = 4'h9;
    step(6);
    chk("addr held", addr, 128'h2A);
    chk("sm roles", sm, 128'hE4);
  endtask : t_addr
  task automatic t_par;
    put(2'h0, 2'h0, 32'hA1);
    put(2'h1, 2'h1, 32'hB2);
    put(2'h2, 2'h2, 32'hC3);
    put(2'h3, 2'h3, 32'hD4);
    wr = 1'b0;
    chk("pend", pend, {32'hD4, 32'hC3, 32'hB2, 32'hA1});
    chk("act", act, {96'h0, 32'hA1});
    stopped = 1'b1;
    step(2);
    stopped = 1'b0;
    chk("act stop", act, {64'h0, 32'hB2, 32'hA1});
    cfg = 1'b1;
    step(1);
    cfg = 1'b0;
    step(2);
    chk("act cfg", act, {32'h0, 32'hC3, 32'hB2, 32'hA1});
  endtask : t_par
  task automatic t_sync;
    sc(2'h0, 32'h000F423F, 1'b1);
    sc(2'h0, 32'h000F4240, 1'b0);
    sc(2'h1, 32'h000F423F, 1'b1);
    sc(2'h1, 32'h003D0900, 1'b0);
    sc(2'h2, 32'h0003D090, 1'b0);
    sc(2'h2, 32'h0007A120, 1'b0);
    sc(2'h2, 32'h000B71B0, 1'b1);
    sc(2'h2, 32'h002DC6C1, 1'b1);
    sc(2'h2, 32'h00895440, 1'b1);
    sc(2'h3, 32'h000F4240, 1'b1);
    for (int k = 1; k <= 8; k++) sc(2'h2, k * 32'h000F4240, 1'b0);
  endtask : t_sync
  task automatic t_gate;
    for (int s = 0; s < 4; s++) begin
      {esm, map} = {s[1:0], 1'b1};
      #1;
      chk("map ok", mok, s == 1);
      step(1);
      chk("enables", {mbx, txe, rxe}, {s > 0, s > 1, s > 2});
    end
    map = 1'b0;
  endtask : t_gate
  task automatic t_pass;
    repeat (8) begin
      step(1);
      chk("dn pass", dtx, upd[2]);
      chk("up pass", utx, dnd[2]);
    end
  endtask : t_pass
  task automatic t_tick;
    int t0;
    sc(2'h2, 32'h000F4240, 1'b0);
    step(20);
    t0 = ticks;
    step(400);
    chk("dc ticks", ticks - t0, 128'h4);
    sc(2'h0, 32'h000F4240, 1'b0);
    t0 = ticks;
    step(400);
    chk("free ticks", ticks - t0, 128'h38);
    sc(2'h2, 32'h000B71B0, 1'b1);
    t0 = ticks;
    step(400);
    chk("err ticks", ticks - t0, 128'h0);
    chk("err txpdo", txe, 1'b0);
  endtask : t_tick
  initial begin
    #100us;
    mismatches++;
    stop_test();
  end
  initial begin
    step(16);
    SYS_RST_I = 1'b0;
    t_addr();
    t_pass();
    t_par();
    t_sync();
    t_gate();
    t_tick();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
